// ---- rtl/monitor_interrupt_status_mask.sv ----
// Second alert status register, two mask registers and interrupt output
//
// How it works
// - Status two sits at 0x02, reads back the flags and ignores writes.
// - Bit 0 flags hot temperature events, with one-time or default mode picked by mask two bit 6.
// - Bit 1 flags the active-low board temperature alert pin, which may be a wired-OR of sensors.
// - Bits 2 and 3 flag the first and second fan count limit being exceeded.
// - Bit 4 flags the chassis intrusion input seen high.
// - Bit 5 flags overtemperature-shutdown events, mode picked by mask two bit 7; bits 6 and 7 are zero.
// - Status two and both masks come up as all zeros after power-on.
// - Mask one at 0x03 is eight read/write bits masking the voltage and external alert flags.
// - Mask two at 0x04 holds read/write bits 0 to 5 masking the status two flags.
// - In default mode a temperature flag clears on read and returns on each conversion while hot.
// - In one-time mode a flag is raised on crossing the hot limit and again on falling below hysteresis.
// - The interrupt output is registered and goes high only on an edge where the interrupt enable bit is set.
`timescale 1ns/1ps
module monitor_interrupt_status_mask
	import mon_alert_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	// Register access from the serial interface
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Configuration and status one flags
	input  wire logic       int_enable_i,
	input  wire logic       soft_init_i,
	input  wire logic [7:0] status_one_i,
	// Hot temperature comparisons
	input  wire logic       conv_done_i,
	input  wire logic       hot_above_limit_i,
	input  wire logic       hot_below_hyst_i,
	// Overtemperature shutdown comparisons
	input  wire logic       overtemp_above_limit_i,
	input  wire logic       overtemp_below_hyst_i,
	// External event inputs
	input  wire logic       board_temp_alert_input_n_i,
	input  wire logic       tach_input_one_over_i,
	input  wire logic       tach_input_two_over_i,
	input  wire logic       intrusion_input_i,
	// Outputs
	output logic [7:0]      alert_status_two_o,
	output logic            int_o
);

	logic [7:0]                  alert_mask_one_r;
	logic [7:0]                  alert_mask_two_r;
	logic [7:0]                  status_two;
	logic [STATUS_TWO_FLAGS-1:0] set_vec;
	logic                        hot_set;
	logic                        overtemp_set;
	logic                        status_two_read;
	logic                        int_r;
	logic                        int_nxt;

	// Register strobes, decoded by address
	logic wr_mask_one;
	logic wr_mask_two;

	always_comb begin
		wr_mask_one     = 1'b0;
		wr_mask_two     = 1'b0;
		status_two_read = 1'b0;
		if (reg_addr_i == ADDR_ALERT_MASK_ONE) begin
			wr_mask_one = reg_wr_i;
		end else if (reg_addr_i == ADDR_ALERT_MASK_TWO) begin
			wr_mask_two = reg_wr_i;
		end else if (reg_addr_i == ADDR_ALERT_STATUS_TWO) begin
			status_two_read = reg_rd_i;
		end
	end

	// Hot temperature event source
	temp_alert_tracker u_hot_tracker (
		.ref_clk_i       (ref_clk_i),
		.nrst_i          (nrst_i),
		.soft_init_i     (soft_init_i),
		.one_time_mode_i (alert_mask_two_r[BIT_HOT_MODE]),
		.conv_done_i     (conv_done_i),
		.above_hot_i     (hot_above_limit_i),
		.below_hyst_i    (hot_below_hyst_i),
		.set_flag_o      (hot_set)
	);

	// Overtemperature shutdown event source
	temp_alert_tracker u_overtemp_tracker (
		.ref_clk_i       (ref_clk_i),
		.nrst_i          (nrst_i),
		.soft_init_i     (soft_init_i),
		.one_time_mode_i (alert_mask_two_r[BIT_OVERTEMP_MODE]),
		.conv_done_i     (conv_done_i),
		.above_hot_i     (overtemp_above_limit_i),
		.below_hyst_i    (overtemp_below_hyst_i),
		.set_flag_o      (overtemp_set)
	);

	// Event vector into status two
	always_comb begin
		set_vec                 = '0;
		set_vec[BIT_HOT_TEMP]   = hot_set;
		set_vec[BIT_BOARD_TEMP] = !board_temp_alert_input_n_i;
		set_vec[BIT_TACH_ONE]   = tach_input_one_over_i;
		set_vec[BIT_TACH_TWO]   = tach_input_two_over_i;
		set_vec[BIT_INTRUSION]  = intrusion_input_i;
		set_vec[BIT_OVERTEMP]   = overtemp_set;
	end

	// Status two flags, cleared by each read
	sticky_status_bank u_status_two (
		.ref_clk_i    (ref_clk_i),
		.nrst_i       (nrst_i),
		.soft_init_i  (soft_init_i),
		.read_clear_i (status_two_read),
		.set_i        (set_vec),
		.flags_o      (status_two)
	);

	assign alert_status_two_o = status_two;

	// Mask one, plain read/write
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alert_mask_one_r <= RST_ALERT_MASK_ONE;
		end else if (soft_init_i) begin
			alert_mask_one_r <= RST_ALERT_MASK_ONE;
		end else if (wr_mask_one) begin
			alert_mask_one_r <= reg_wdata_i;
		end
	end

	// Mask two, masks plus mode selects
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alert_mask_two_r <= RST_ALERT_MASK_TWO;
		end else if (soft_init_i) begin
			alert_mask_two_r <= RST_ALERT_MASK_TWO;
		end else if (wr_mask_two) begin
			alert_mask_two_r <= reg_wdata_i;
		end
	end

	// Read data, captured on the read strobe
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			if (reg_addr_i == ADDR_ALERT_STATUS_TWO) begin
				reg_rdata_o <= status_two;
			end else if (reg_addr_i == ADDR_ALERT_MASK_ONE) begin
				reg_rdata_o <= alert_mask_one_r;
			end else if (reg_addr_i == ADDR_ALERT_MASK_TWO) begin
				reg_rdata_o <= alert_mask_two_r;
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	// Interrupt request from unmasked flags of both groups
	always_comb begin
		int_nxt = int_enable_i &&
			(any_unmasked(status_one_i, alert_mask_one_r) ||
			any_unmasked(status_two, {2'b11, alert_mask_two_r[5:0]}));
	end

	// Registered interrupt output
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			int_r <= 1'b0;
		end else begin
			int_r <= int_nxt;
		end
	end

	assign int_o = int_r;

endmodule : monitor_interrupt_status_mask

// ---- rtl/mon_alert_pkg.sv ----
// Shared constants for the monitor alert status and mask logic
package mon_alert_pkg;

	// Register indices on the address pointer
	localparam logic [7:0] ADDR_ALERT_STATUS_TWO = 8'h02;
	localparam logic [7:0] ADDR_ALERT_MASK_ONE   = 8'h03;
	localparam logic [7:0] ADDR_ALERT_MASK_TWO   = 8'h04;

	// Power-on values
	localparam logic [7:0] RST_ALERT_STATUS_TWO = 8'h00;
	localparam logic [7:0] RST_ALERT_MASK_ONE   = 8'h00;
	localparam logic [7:0] RST_ALERT_MASK_TWO   = 8'h00;

	// Status two field positions
	localparam int BIT_HOT_TEMP   = 0;
	localparam int BIT_BOARD_TEMP = 1;
	localparam int BIT_TACH_ONE   = 2;
	localparam int BIT_TACH_TWO   = 3;
	localparam int BIT_INTRUSION  = 4;
	localparam int BIT_OVERTEMP   = 5;
	localparam int STATUS_TWO_FLAGS = 6;

	// Mask two mode select positions
	localparam int BIT_HOT_MODE      = 6;
	localparam int BIT_OVERTEMP_MODE = 7;

	// Tracker state
	typedef enum logic [1:0] {
		TEMP_NORMAL = 2'b01,
		TEMP_HOT    = 2'b10
	} temp_state_type;

	// Unmasked flag reduction, used for both status groups
	function automatic logic any_unmasked(input logic [7:0] flags, input logic [7:0] mask);
		any_unmasked = |(flags & ~mask);
	endfunction : any_unmasked

endpackage : mon_alert_pkg

// ---- rtl/temp_alert_tracker.sv ----
// Temperature alert event source with default and one-time modes
`timescale 1ns/1ps
module temp_alert_tracker
	import mon_alert_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	// Control
	input  wire logic soft_init_i,
	input  wire logic one_time_mode_i,
	// Conversion results
	input  wire logic conv_done_i,
	input  wire logic above_hot_i,
	input  wire logic below_hyst_i,
	// Event to the status flag
	output logic      set_flag_o
);

	temp_state_type state_r;
	temp_state_type state_nxt;

	// Hot region entered above hot limit, left below hysteresis
	always_comb begin
		state_nxt  = state_r;
		set_flag_o = 1'b0;
		case (state_r)
			TEMP_NORMAL: begin
				if (conv_done_i && above_hot_i) begin
					state_nxt  = TEMP_HOT;
					set_flag_o = 1'b1;
				end
			end
			TEMP_HOT: begin
				if (conv_done_i && below_hyst_i) begin
					state_nxt  = TEMP_NORMAL;
					set_flag_o = one_time_mode_i;
				end else if (conv_done_i) begin
					set_flag_o = !one_time_mode_i;
				end
			end
			default: begin
				state_nxt = TEMP_NORMAL;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= TEMP_NORMAL;
		end else if (soft_init_i) begin
			state_r <= TEMP_NORMAL;
		end else begin
			state_r <= state_nxt;
		end
	end

endmodule : temp_alert_tracker

// ---- rtl/sticky_status_bank.sv ----
// Sticky status flags cleared by a read, set winning over clear
`timescale 1ns/1ps
module sticky_status_bank
	import mon_alert_pkg::*;
(
	// Clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        nrst_i,
	// Control
	input  wire logic                        soft_init_i,
	input  wire logic                        read_clear_i,
	input  wire logic [STATUS_TWO_FLAGS-1:0] set_i,
	// Flags
	output logic      [7:0]                  flags_o
);

	logic [STATUS_TWO_FLAGS-1:0] flags_r;

	// Clear on read, a same-cycle set survives
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_r <= RST_ALERT_STATUS_TWO[STATUS_TWO_FLAGS-1:0];
		end else if (soft_init_i) begin
			flags_r <= RST_ALERT_STATUS_TWO[STATUS_TWO_FLAGS-1:0];
		end else if (read_clear_i) begin
			flags_r <= set_i;
		end else begin
			flags_r <= flags_r | set_i;
		end
	end

	// Reserved bits 6 and 7 read as zero
	assign flags_o = {2'b00, flags_r};

endmodule : sticky_status_bank

// ---- dv/mon_host_model.sv ----
// Register host model driving the strobe access port
`timescale 1ns/1ps
module mon_host_model (
	// Register port
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o
);
	// Idle bus
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end
	// One write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk_i) #1;
		reg_addr_o = a;
		reg_wdata_o = v;
		reg_wr_o = 1'b1;
		@(posedge ref_clk_i) #1;
		reg_wr_o = 1'b0;
		reg_wdata_o = ~v;
	endtask : wr
	// One read strobe, data after the edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk_i) #1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge ref_clk_i) #1;
		reg_rd_o = 1'b0;
		v = reg_rdata_i;
	endtask : rd
endmodule : mon_host_model

// ---- dv/monitor_interrupt_status_mask_asserts.sv ----
// Port checker for the alert status, mask and interrupt logic
`timescale 1ns/1ps
module monitor_interrupt_status_mask_asserts
	import mon_alert_pkg::*;
(
	// Watched ports
	input wire logic       ref_clk_i,
	input wire logic       nrst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       int_enable_i,
	input wire logic       soft_init_i,
	input wire logic [7:0] status_one_i,
	input wire logic       board_temp_alert_input_n_i,
	input wire logic       tach_input_one_over_i,
	input wire logic       intrusion_input_i,
	input wire logic [7:0] alert_status_two_o,
	input wire logic       int_o
);
	logic [7:0] m1_r;
	logic [7:0] m2_r;
	logic       int_exp;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// Shadow copies of both masks
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			m1_r <= RST_ALERT_MASK_ONE;
			m2_r <= RST_ALERT_MASK_TWO;
		end else if (soft_init_i) begin
			m1_r <= RST_ALERT_MASK_ONE;
			m2_r <= RST_ALERT_MASK_TWO;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_ALERT_MASK_ONE) begin
				m1_r <= reg_wdata_i;
			end
			if (reg_addr_i == ADDR_ALERT_MASK_TWO) begin
				m2_r <= reg_wdata_i;
			end
		end
	end
	// Expected interrupt level, seen one edge later on the output
	assign int_exp = int_enable_i && (|(status_one_i & ~m1_r) || |(alert_status_two_o[5:0] & ~m2_r[5:0]));
	// Board alert seen low
	sequence s_board_low;
		!board_temp_alert_input_n_i && !soft_init_i;
	endsequence
	// Enable seen low on two edges in a row
	sequence s_off_twice;
		!int_enable_i ##1 !int_enable_i;
	endsequence
	a_status_read: assert property (
		reg_rd_i && reg_addr_i == ADDR_ALERT_STATUS_TWO |=> reg_rdata_o == $past(alert_status_two_o))
		else $error("status read wrong");
	a_board_flag: assert property (s_board_low |=> alert_status_two_o[1])
		else $error("board flag missing");
	a_tach_flag: assert property (tach_input_one_over_i && !soft_init_i |=> alert_status_two_o[2])
		else $error("tach flag missing");
	a_intrusion_flag: assert property (intrusion_input_i && !soft_init_i |=> alert_status_two_o[4])
		else $error("intrusion flag missing");
	a_reserved_zero: assert property (alert_status_two_o[7:6] == 2'b00)
		else $error("reserved bits set");
	a_mask_one_read: assert property (
		reg_rd_i && reg_addr_i == ADDR_ALERT_MASK_ONE |=> reg_rdata_o == $past(m1_r))
		else $error("mask one read wrong");
	a_mask_two_read: assert property (
		reg_rd_i && reg_addr_i == ADDR_ALERT_MASK_TWO |=> reg_rdata_o == $past(m2_r))
		else $error("mask two read wrong");
	a_enable_gate: assert property (s_off_twice |-> !int_o)
		else $error("interrupt while disabled");
	a_int_level: assert property (int_o == $past(int_exp))
		else $error("interrupt level wrong");
endmodule : monitor_interrupt_status_mask_asserts

bind monitor_interrupt_status_mask monitor_interrupt_status_mask_asserts u_chk (
	.ref_clk_i                  (ref_clk_i),
	.nrst_i                     (nrst_i),
	.reg_addr_i                 (reg_addr_i),
	.reg_wdata_i                (reg_wdata_i),
	.reg_wr_i                   (reg_wr_i),
	.reg_rd_i                   (reg_rd_i),
	.reg_rdata_o                (reg_rdata_o),
	.int_enable_i               (int_enable_i),
	.soft_init_i                (soft_init_i),
	.status_one_i               (status_one_i),
	.board_temp_alert_input_n_i (board_temp_alert_input_n_i),
	.tach_input_one_over_i      (tach_input_one_over_i),
	.intrusion_input_i          (intrusion_input_i),
	.alert_status_two_o         (alert_status_two_o),
	.int_o                      (int_o)
);

// ---- dv/test_monitor_interrupt_status_mask.sv ----
// Self-checking bench for the alert status and mask block
`timescale 1ns/1ps
module test_monitor_interrupt_status_mask;
	import mon_alert_pkg::*;
	localparam logic [7:0] MK2 = 8'h5a;
	logic       ref_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i, reg_rd_i, int_o, conv_done_i = 1'b0;
	logic       int_enable_i = 1'b1, soft_init_i = 1'b0;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, alert_status_two_o, d, status_one_i = 8'h00;
	logic [4:1] ev = 4'h0;
	logic [1:0] ab = 2'b00, bl = 2'b00;
	int         errors = 0, n_checks = 0;
	// Event and comparison inputs
	wire board_temp_alert_input_n_i = ~ev[1], tach_input_one_over_i = ev[2];
	wire tach_input_two_over_i = ev[3], intrusion_input_i = ev[4];
	wire hot_above_limit_i = ab[0], hot_below_hyst_i = bl[0];
	wire overtemp_above_limit_i = ab[1], overtemp_below_hyst_i = bl[1];
	monitor_interrupt_status_mask DUT (
		.ref_clk_i                  (ref_clk_i),
		.nrst_i                     (nrst_i),
		.reg_addr_i                 (reg_addr_i),
		.reg_wdata_i                (reg_wdata_i),
		.reg_wr_i                   (reg_wr_i),
		.reg_rd_i                   (reg_rd_i),
		.reg_rdata_o                (reg_rdata_o),
		.int_enable_i               (int_enable_i),
		.soft_init_i                (soft_init_i),
		.status_one_i               (status_one_i),
		.conv_done_i                (conv_done_i),
		.hot_above_limit_i          (hot_above_limit_i),
		.hot_below_hyst_i           (hot_below_hyst_i),
		.overtemp_above_limit_i     (overtemp_above_limit_i),
		.overtemp_below_hyst_i      (overtemp_below_hyst_i),
		.board_temp_alert_input_n_i (board_temp_alert_input_n_i),
		.tach_input_one_over_i      (tach_input_one_over_i),
		.tach_input_two_over_i      (tach_input_two_over_i),
		.intrusion_input_i          (intrusion_input_i),
		.alert_status_two_o         (alert_status_two_o),
		.int_o                      (int_o)
	);
	mon_host_model host (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
	// Clock
	initial forever #12.5 ref_clk_i = ~ref_clk_i;
	// Compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Verdict
	task automatic stop_test;
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	// Status read
	task automatic rs(input logic [7:0] e);
		host.rd(ADDR_ALERT_STATUS_TWO, d);
		chk(d, e);
	endtask : rs
	// One conversion
	task automatic cv(input int t, input logic a, input logic b);
		@(posedge ref_clk_i) #1;
		ab[t] = a;
		bl[t] = b;
		conv_done_i = 1'b1;
		@(posedge ref_clk_i) #1;
		conv_done_i = 1'b0;
		ab = 2'b00;
		bl = 2'b00;
	endtask : cv
	// Watchdog
	initial begin
		#50us;
		errors++;
		stop_test();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk_i);
		#1 nrst_i = 1'b1;
		for (int a = 2; a < 6; a++) begin
			host.rd(8'(a), d);
			chk(d, 8'h00);
		end
		host.wr(ADDR_ALERT_MASK_ONE, 8'ha5);
		host.wr(ADDR_ALERT_MASK_TWO, MK2);
		host.wr(ADDR_ALERT_STATUS_TWO, 8'hff);
		host.rd(ADDR_ALERT_MASK_ONE, d);
		chk(d, 8'ha5);
		host.rd(ADDR_ALERT_MASK_TWO, d);
		chk(d, MK2);
		rs(8'h00);
		status_one_i = 8'h01;
		repeat (3) @(posedge ref_clk_i) #1;
		chk(int_o, 8'h00);
		status_one_i = 8'h02;
		repeat (3) @(posedge ref_clk_i) #1;
		chk(int_o, 8'h01);
		int_enable_i = 1'b0;
		repeat (3) @(posedge ref_clk_i) #1;
		chk(int_o, 8'h00);
		int_enable_i = 1'b1;
		status_one_i = 8'h00;
		for (int b = 1; b < 5; b++) begin
			@(posedge ref_clk_i) #1;
			ev[b] = 1'b1;
			@(posedge ref_clk_i) #1;
			ev[b] = 1'b0;
			chk(alert_status_two_o, 8'h01 << b);
			@(posedge ref_clk_i) #1;
			chk(int_o, {7'h00, !MK2[b]});
			rs(8'h01 << b);
			chk(alert_status_two_o, 8'h00);
			@(posedge ref_clk_i) #1;
			chk(int_o, 8'h00);
		end
		for (int t = 0; t < 2; t++) begin
			cv(t, 1'b1, 1'b0);
			rs(8'h01 << (t * 5));
			cv(t, 1'b1, 1'b0);
			rs(t == 1 ? 8'h20 : 8'h00);
			cv(t, 1'b0, 1'b1);
			rs(t == 0 ? 8'h01 : 8'h00);
		end
		@(posedge ref_clk_i) #1;
		soft_init_i = 1'b1;
		@(posedge ref_clk_i) #1;
		soft_init_i = 1'b0;
		host.rd(ADDR_ALERT_MASK_TWO, d);
		chk(d, 8'h00);
		host.rd(ADDR_ALERT_MASK_ONE, d);
		chk(d, 8'h00);
		stop_test();
	end
endmodule : test_monitor_interrupt_status_mask
